// ===== bench/pmc_top_tb.sv
// self-checking testbench of the power-mode controller
`timescale 1ns/1ns
`default_nettype none
`include "pmc_map.svh"
module pmc_top_tb;
	import pmc_pkg::*;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = 32'h0;
	logic [3:0]        wstrb = 4'hf;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp;
	logic [31:0]       rdata;
	pmc_evt_t          evt = '0;
	logic              rst_pin_n = 1'b1, debug_halt = 1'b0, io_hold, core_rst, irq;
	logic [7:0]        wake_pin = 8'h00, gpio_out = 8'h00, pad_out, g0;
	pmc_pwr_t          pwr;
	pmc_mode_t         mode;
	logic [33:0]       rd_q[$];
	logic [1:0]        wr_q[$];
	int                fail_count = 0, total_checks = 0, cyc = 0, k;

	pmc_top #(.IO_W(8)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .evt(evt), .rst_pin_n(rst_pin_n),
		.wake_pin(wake_pin), .debug_halt(debug_halt), .gpio_out(gpio_out), .pad_out(pad_out),
		.io_hold(io_hold), .pwr(pwr), .mode(mode), .core_rst(core_rst), .irq(irq));

	always #20 aclk = ~aclk;

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// cycle ceiling cuts a hang short
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fail_count++;
			summarize();
		end
	end

	// response watcher: oldest note is compared when a response is handed over
	always @(posedge aclk)
	begin
		if (bvalid === 1'b1 && bready === 1'b1)
		begin
			if (wr_q.size() == 0)
				chk("unexpected bresp", 32'h0, 32'h1);
			else
				chk("bresp", {30'h0, wr_q.pop_front()}, {30'h0, bresp});
		end
		if (rvalid === 1'b1 && rready === 1'b1)
		begin
			if (rd_q.size() == 0)
				chk("unexpected rvalid", 32'h0, 32'h1);
			else
			begin
				logic [33:0] n;
				n = rd_q.pop_front();
				chk("rresp", {30'h0, n[33:32]}, {30'h0, rresp});
				chk("rdata", n[31:0], rdata);
			end
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		wr_q.push_back(er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid === 1'b1));
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		rd_q.push_back({er, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid === 1'b1));
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic wait_mode(input pmc_mode_t m);
		while (mode !== m)
			@(posedge aclk);
	endtask : wait_mode

	task automatic pulse(input int b);
		evt[b] <= 1'b1;
		@(posedge aclk);
		evt[b] <= 1'b0;
		@(posedge aclk);
	endtask : pulse

	task automatic tdone(input string n);
		$display("test %s done", n);
	endtask : tdone

	initial
	begin
		void'($urandom(52770));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		gpio_out <= 8'($urandom);
		repeat (3) @(posedge aclk);
		// reset state and register map
		rd(`PMC_A_STAT, 32'h0, `PMC_RESP_OK);
		rd(`PMC_A_WLD, `PMC_WLD_RST, `PMC_RESP_OK);
		rd(8'h1c, 32'h0, `PMC_RESP_ERR);
		wr(8'h20, 32'h0, `PMC_RESP_ERR);
		chk("act cpu", 32'h1, {31'h0, pwr.cpu_clk});
		chk("act mem", 32'h3, {30'h0, pwr.flash_on, pwr.sram_on});
		chk("act radio", 32'h1, {31'h0, pwr.radio_avail});
		chk("act clks", 32'h7, {29'h0, pwr.hf_clk_en, pwr.mf_clk_en, pwr.lf_clk_en});
		chk("act ret", 32'h1, {31'h0, pwr.reg_ret_full});
		chk("act mon", 32'h3, {30'h0, pwr.bod_en, pwr.por_mon});
		wr(`PMC_A_CTRL, 32'h0c, `PMC_RESP_OK);
		chk("xtal src", 32'h3, {30'h0, pwr.hf_src_xtal, pwr.lf_src_xtal});
		rd(`PMC_A_CTRL, 32'h0c, `PMC_RESP_OK);
		tdone("reset");
		// idle and interrupt wake
		wr(`PMC_A_CTRL, 32'h1, `PMC_RESP_OK);
		chk("idle mode", {29'h0, PM_IDLE}, {29'h0, mode});
		chk("idle cpu", 32'h0, {31'h0, pwr.cpu_clk});
		chk("idle clks", 32'h7, {29'h0, pwr.hf_clk_en, pwr.periph_clk, pwr.lf_clk_en});
		pulse(0);
		chk("idle wake", {29'h0, PM_ACTIVE}, {29'h0, mode});
		tdone("idle");
		// standby with each event wake source (battery, sensor, rtc), pads frozen
		for (int i = 1; i < 4; i++)
		begin
			g0 = gpio_out;
			wr(`PMC_A_CTRL, 32'h2, `PMC_RESP_OK);
			chk("sb mode", {29'h0, PM_STANDBY}, {29'h0, mode});
			chk("sb hold", 32'h1, {31'h0, io_hold});
			chk("sb clks", 32'h3, {29'h0, pwr.hf_clk_en, pwr.mf_clk_en, pwr.lf_clk_en});
			chk("sb ret", 32'h3, {30'h0, pwr.sram_ret, pwr.reg_ret_part});
			chk("sb por", 32'h1, {31'h0, pwr.por_mon});
			gpio_out <= ~g0;
			k = 0;
			repeat (16)
			begin
				@(posedge aclk);
				k += pwr.bod_en;
			end
			chk("sb bod duty", 32'h1, k);
			chk("sb supply", 32'h1, {31'h0, pwr.supply_duty});
			chk("sb pad", {24'h0, g0}, {24'h0, pad_out});
			pulse(i);
			wait_mode(PM_ACTIVE);
			chk("sb resume", 32'h0, {31'h0, core_rst});
			wr(`PMC_A_ISR, 32'h1f, `PMC_RESP_OK);
		end
		tdone("standby");
		// battery event sets status, masked and unmasked interrupt
		pulse(1);
		rd(`PMC_A_ISR, 32'h2, `PMC_RESP_OK);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`PMC_A_IMR, 32'h2, `PMC_RESP_OK);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(`PMC_A_ISR, 32'h2, `PMC_RESP_OK);
		chk("irq clr", 32'h0, {31'h0, irq});
		tdone("interrupt");
		// shutdown: only an enabled wake pin wakes, through reset
		k = $urandom % 8;
		wr(`PMC_A_WCFG, 32'h1 << k, `PMC_RESP_OK);
		wr(`PMC_A_CTRL, 32'h3, `PMC_RESP_OK);
		chk("sd mode", {29'h0, PM_SHUTDOWN}, {29'h0, mode});
		chk("sd off", 32'h0, {27'h0, pwr.aon_on, pwr.sensor_ctl_on, pwr.hf_clk_en, pwr.bod_en, pwr.por_mon});
		chk("sd hold", 32'h1, {31'h0, io_hold});
		wake_pin <= wake_pin ^ ~(8'h1 << k);
		pulse(3);
		repeat (5) @(posedge aclk);
		chk("sd stay", {29'h0, PM_SHUTDOWN}, {29'h0, mode});
		wake_pin <= wake_pin ^ (8'h1 << k);
		wait_mode(PM_HELD);
		chk("sd reset", 32'h1, {31'h0, core_rst});
		wait_mode(PM_ACTIVE);
		rd(`PMC_A_STAT, 32'h20, `PMC_RESP_OK);
		tdone("shutdown");
		// reset pin
		rst_pin_n <= 1'b0;
		wait_mode(PM_HELD);
		chk("pin held", 32'h0, {30'h0, pwr.hf_clk_en, pwr.cpu_clk});
		repeat (5) @(posedge aclk);
		rst_pin_n <= 1'b1;
		wait_mode(PM_ACTIVE);
		rd(`PMC_A_STAT, 32'h10, `PMC_RESP_OK);
		tdone("reset pin");
		// watchdog: paused by debug halt, not stoppable, bark then reset
		debug_halt <= 1'b1;
		wr(`PMC_A_WLD, 32'h2, `PMC_RESP_OK);
		wr(`PMC_A_WKICK, 32'h0, `PMC_RESP_OK);
		wr(`PMC_A_IMR, 32'h1, `PMC_RESP_OK);
		wr(`PMC_A_CTRL, 32'h10, `PMC_RESP_OK);
		repeat (150) @(posedge aclk);
		rd(`PMC_A_ISR, 32'h0, `PMC_RESP_OK);
		wr(`PMC_A_CTRL, 32'h0, `PMC_RESP_OK);
		rd(`PMC_A_CTRL, 32'h10, `PMC_RESP_OK);
		debug_halt <= 1'b0;
		k = 0;
		while (irq !== 1'b1 && k < 120)
		begin
			@(posedge aclk);
			k++;
		end
		chk("wdt bark", 32'h1, {31'h0, irq});
		wait_mode(PM_HELD);
		wait_mode(PM_ACTIVE);
		rd(`PMC_A_STAT, 32'h30, `PMC_RESP_OK);
		tdone("watchdog");
		summarize();
	end
endmodule : pmc_top_tb
`default_nettype wire

// ===== logic/pmc_map.svh
// register map, field positions, reset values and timing counts of the power-mode controller
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_A_CTRL 8'h00
`define PMC_A_STAT 8'h04
`define PMC_A_ISR 8'h08
`define PMC_A_IMR 8'h0c
`define PMC_A_WLD 8'h10
`define PMC_A_WKICK 8'h14
`define PMC_A_WCFG 8'h18
`define PMC_CTRL_HFX 2
`define PMC_CTRL_LFX 3
`define PMC_CTRL_WEN 4
`define PMC_STAT_CAUSE 4
`define PMC_ISR_WDT 0
`define PMC_ISR_BAT 1
`define PMC_ISR_RTC 2
`define PMC_ISR_SEN 3
`define PMC_ISR_PIN 4
`define PMC_ISR_W 5
`define PMC_WLD_RST 32'h0000ffff
`define PMC_CLK_NS 40
`define PMC_WDT_NS 667
`define PMC_HOLD_CYC 4'h8
`define PMC_BOD_DUTY 4'hf
`define PMC_RESP_OK 2'h0
`define PMC_RESP_ERR 2'h2
`endif

// ===== logic/pmc_pkg.sv
// types of the power-mode controller
package pmc_pkg;
	typedef enum logic [2:0] {PM_ACTIVE, PM_IDLE, PM_STANDBY, PM_SHUTDOWN, PM_HELD} pmc_mode_t;
	typedef enum logic [1:0] {RC_POR, RC_PIN, RC_WAKE, RC_WDT} pmc_cause_t;
	typedef struct packed {
		logic cpu_clk;
		logic flash_on;
		logic sram_on;
		logic sram_ret;
		logic reg_ret_full;
		logic reg_ret_part;
		logic radio_avail;
		logic periph_clk;
		logic hf_clk_en;
		logic hf_src_xtal;
		logic mf_clk_en;
		logic lf_clk_en;
		logic lf_src_xtal;
		logic sensor_ctl_on;
		logic aon_on;
		logic supply_duty;
		logic bod_en;
		logic por_mon;
	} pmc_pwr_t;
	typedef struct packed {
		logic rtc;
		logic sensor;
		logic batmon;
		logic cpu_irq;
	} pmc_evt_t;
endpackage : pmc_pkg

// ===== logic/pmc_top.sv
// power-mode controller with AXI4-Lite registers, watchdog and wake logic
// Notes on behaviour
// - active: cpu runs, memories, radio, peripherals on
// - idle: cpu unclocked, memory on, any interrupt wakes
// - standby: only always-on; pin, rtc, sensor wake
// - standby wake resumes cpu without reset
// - io pins latched during standby
// - shutdown: all off, io latched, flash off
// - shutdown wake pin change triggers reset
// - reset cause readable: pin, wake, power-on
// - watchdog ticks 1.5 MHz, enable is sticky
// - watchdog pauses standby/debug, off shutdown/held
// - missed service: interrupt first, then reset
// - fast clock only in active and idle
// - medium clock also available in standby
// - slow clock runs through standby
// - retention: full active/idle, partial standby
// - reset pin always; rtc wake not shutdown
// - battery/temp events interrupt and wake standby
`timescale 1ns/1ns
`default_nettype none
`include "pmc_map.svh"
module pmc_top #(
	parameter int IO_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	input  wire pmc_pkg::pmc_evt_t evt,
	input  wire logic              rst_pin_n,
	input  wire logic [IO_W-1:0]   wake_pin,
	input  wire logic              debug_halt,
	input  wire logic [IO_W-1:0]   gpio_out,
	output var  logic [IO_W-1:0]   pad_out,
	output var  logic              io_hold,
	output var  pmc_pkg::pmc_pwr_t pwr,
	output var  pmc_pkg::pmc_mode_t mode,
	output var  logic              core_rst,
	output var  logic              irq
);
	import pmc_pkg::*;

	localparam int WDIV = (`PMC_WDT_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS;

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction : wmerge

	pmc_mode_t         mode_ff, nxt_mode;
	pmc_cause_t        cause_ff;
	pmc_pwr_t          pwr_ff;
	logic              rp1_ff, rp2_ff, dh1_ff, dh2_ff;
	logic [IO_W-1:0]   wk1_ff, wk2_ff, ref_ff, wcfg_ff, pad_ff;
	logic              hold_ff, rst_ff, irq_ff;
	logic [3:0]        hcnt_ff, bd_ff;
	logic [4:0]        div_ff;
	logic              hfx_ff, lfx_ff, wen_ff;
	logic [31:0]       wld_ff, wcnt_ff;
	logic [`PMC_ISR_W-1:0] isr_ff, imr_ff, isr_set;
	logic              awr_ff, wr_ff, bv_ff, arr_ff, rv_ff, haw_ff, hw_ff;
	logic [1:0]        br_ff, rr_ff;
	logic [7:0]        aa_ff;
	logic [31:0]       wd_ff, rd_ff;
	logic [3:0]        ws_ff;
	logic              nxt_haw, nxt_hw, nxt_bv, nxt_rv;
	logic              wr_do, req_v, pin_chg, sb_wake, idle_wake, sd_wake;
	logic              tick, wrun, bark, bite, kick, hit;
	pmc_mode_t         req_m;

	// two-stage synchronisers for pin and debug inputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rp1_ff <= 1'b1;
			rp2_ff <= 1'b1;
			dh1_ff <= 1'b0;
			dh2_ff <= 1'b0;
			wk1_ff <= '0;
			wk2_ff <= '0;
		end
		else
		begin
			rp1_ff <= rst_pin_n;
			rp2_ff <= rp1_ff;
			dh1_ff <= debug_halt;
			dh2_ff <= dh1_ff;
			wk1_ff <= wake_pin;
			wk2_ff <= wk1_ff;
		end
	end

	// bus write path: address and data taken in either order
	assign wr_do = haw_ff && hw_ff && !bv_ff;
	always_comb
	begin
		nxt_haw = (haw_ff || (awvalid && awr_ff)) && !wr_do;
		nxt_hw = (hw_ff || (wvalid && wr_ff)) && !wr_do;
		nxt_bv = wr_do || (bv_ff && !bready);
		nxt_rv = (arvalid && arr_ff) || (rv_ff && !rready);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{haw_ff, hw_ff, bv_ff, rv_ff} <= 4'h0;
			{awr_ff, wr_ff, arr_ff} <= 3'h0;
			br_ff <= `PMC_RESP_OK;
			aa_ff <= 8'h00;
			wd_ff <= 32'h0;
			ws_ff <= 4'h0;
		end
		else
		begin
			haw_ff <= nxt_haw;
			hw_ff <= nxt_hw;
			bv_ff <= nxt_bv;
			rv_ff <= nxt_rv;
			awr_ff <= !nxt_haw && !nxt_bv && !wr_do;
			wr_ff <= !nxt_hw && !nxt_bv && !wr_do;
			arr_ff <= !nxt_rv;
			if (awvalid && awr_ff)
				aa_ff <= awaddr;
			if (wvalid && wr_ff)
			begin
				wd_ff <= wdata;
				ws_ff <= wstrb;
			end
			if (wr_do)
				br_ff <= hit ? `PMC_RESP_OK : `PMC_RESP_ERR;
		end
	end

	always_comb
	begin
		unique case (aa_ff & 8'hfc)
			`PMC_A_CTRL, `PMC_A_ISR, `PMC_A_IMR, `PMC_A_WLD, `PMC_A_WKICK, `PMC_A_WCFG: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// read path, one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_ff <= 32'h0;
			rr_ff <= `PMC_RESP_OK;
		end
		else if (arvalid && arr_ff)
		begin
			rr_ff <= `PMC_RESP_OK;
			unique case (araddr & 8'hfc)
				`PMC_A_CTRL: rd_ff <= 32'({wen_ff, lfx_ff, hfx_ff, 2'h0});
				`PMC_A_STAT: rd_ff <= 32'({cause_ff, 1'b0, mode_ff});
				`PMC_A_ISR: rd_ff <= 32'(isr_ff);
				`PMC_A_IMR: rd_ff <= 32'(imr_ff);
				`PMC_A_WLD: rd_ff <= wld_ff;
				`PMC_A_WKICK: rd_ff <= wcnt_ff;
				`PMC_A_WCFG: rd_ff <= 32'(wcfg_ff);
				default:
				begin
					rd_ff <= 32'h0;
					rr_ff <= `PMC_RESP_ERR;
				end
			endcase
		end
	end

	// software mode request, honoured only while the cpu runs
	always_comb
	begin
		unique case (wd_ff[1:0])
			2'h1: req_m = PM_IDLE;
			2'h2: req_m = PM_STANDBY;
			2'h3: req_m = PM_SHUTDOWN;
			default: req_m = PM_ACTIVE;
		endcase
	end
	assign req_v = wr_do && aa_ff == `PMC_A_CTRL && ws_ff[0] && wd_ff[1:0] != 2'h0 && mode_ff == PM_ACTIVE;

	assign pin_chg = |((wk2_ff ^ ref_ff) & wcfg_ff);
	assign sb_wake = evt.rtc || evt.sensor || evt.batmon || pin_chg;
	assign idle_wake = evt.cpu_irq || irq_ff;
	assign sd_wake = mode_ff == PM_SHUTDOWN && pin_chg;

	always_comb
	begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			PM_ACTIVE: if (req_v) nxt_mode = req_m;
			PM_IDLE: if (idle_wake) nxt_mode = PM_ACTIVE;
			PM_STANDBY: if (sb_wake) nxt_mode = PM_ACTIVE;
			PM_SHUTDOWN: nxt_mode = PM_SHUTDOWN;
			PM_HELD: if (rp2_ff && hcnt_ff == 4'h0) nxt_mode = PM_ACTIVE;
		endcase
		if (!rp2_ff || bite || sd_wake)
			nxt_mode = PM_HELD;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_ff <= PM_ACTIVE;
			cause_ff <= RC_POR;
			hcnt_ff <= 4'h0;
			rst_ff <= 1'b0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			rst_ff <= nxt_mode == PM_HELD;
			if (nxt_mode == PM_HELD && mode_ff != PM_HELD)
				hcnt_ff <= `PMC_HOLD_CYC;
			else if (hcnt_ff != 4'h0)
				hcnt_ff <= hcnt_ff - 4'h1;
			// the pin outranks a cause recorded earlier in the same hold
			if (!rp2_ff)
				cause_ff <= RC_PIN;
			else if (nxt_mode == PM_HELD && mode_ff != PM_HELD)
				cause_ff <= bite ? RC_WDT : RC_WAKE;
		end
	end

	// io latch: pads freeze at entry to standby or shutdown
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pad_ff <= '0;
			hold_ff <= 1'b0;
			ref_ff <= '0;
		end
		else
		begin
			hold_ff <= nxt_mode == PM_STANDBY || nxt_mode == PM_SHUTDOWN;
			if (nxt_mode != PM_STANDBY && nxt_mode != PM_SHUTDOWN)
				pad_ff <= gpio_out;
			if (mode_ff != PM_STANDBY && mode_ff != PM_SHUTDOWN)
				ref_ff <= wk2_ff;
		end
	end

	// dividers: watchdog tick and brownout duty cycle
	assign tick = div_ff == 5'(WDIV - 1);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_ff <= 5'h0;
			bd_ff <= 4'h0;
		end
		else
		begin
			div_ff <= tick ? 5'h0 : div_ff + 5'h1;
			bd_ff <= bd_ff == `PMC_BOD_DUTY ? 4'h0 : bd_ff + 4'h1;
		end
	end

	// watchdog: first expiry barks, second unserviced expiry bites
	assign wrun = wen_ff && (mode_ff == PM_ACTIVE || mode_ff == PM_IDLE) && !dh2_ff;
	assign kick = wr_do && aa_ff == `PMC_A_WKICK && (mode_ff == PM_ACTIVE || mode_ff == PM_IDLE);
	assign bark = wrun && tick && wcnt_ff == 32'h0 && !isr_ff[`PMC_ISR_WDT];
	assign bite = wrun && tick && wcnt_ff == 32'h0 && isr_ff[`PMC_ISR_WDT];
	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode_ff == PM_HELD || mode_ff == PM_SHUTDOWN)
		begin
			wen_ff <= 1'b0;
			wcnt_ff <= `PMC_WLD_RST;
			wld_ff <= `PMC_WLD_RST;
		end
		else
		begin
			if (wr_do && aa_ff == `PMC_A_CTRL && ws_ff[0] && wd_ff[`PMC_CTRL_WEN])
				wen_ff <= 1'b1;
			if (wr_do && aa_ff == `PMC_A_WLD)
				wld_ff <= wmerge(wld_ff, wd_ff, ws_ff);
			if (kick)
				wcnt_ff <= wld_ff;
			else if (wrun && tick)
				wcnt_ff <= wcnt_ff == 32'h0 ? wld_ff : wcnt_ff - 32'h1;
		end
	end

	// control, wake config, sticky status and mask
	assign isr_set = {mode_ff == PM_STANDBY && pin_chg, evt.sensor, evt.rtc && mode_ff != PM_SHUTDOWN,
		evt.batmon && mode_ff != PM_SHUTDOWN, bark};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wcfg_ff <= '0;
		else if (wr_do && aa_ff == `PMC_A_WCFG)
			wcfg_ff <= IO_W'(wmerge(32'(wcfg_ff), wd_ff, ws_ff));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode_ff == PM_HELD)
		begin
			isr_ff <= '0;
			imr_ff <= '0;
			hfx_ff <= 1'b0;
			lfx_ff <= 1'b0;
			irq_ff <= 1'b0;
		end
		else
		begin
			if (wr_do && aa_ff == `PMC_A_ISR && ws_ff[0])
				isr_ff <= (isr_ff & ~wd_ff[`PMC_ISR_W-1:0]) | isr_set;
			else
				isr_ff <= isr_ff | isr_set;
			if (wr_do && aa_ff == `PMC_A_IMR && ws_ff[0])
				imr_ff <= wd_ff[`PMC_ISR_W-1:0];
			if (wr_do && aa_ff == `PMC_A_CTRL && ws_ff[0])
			begin
				hfx_ff <= wd_ff[`PMC_CTRL_HFX];
				lfx_ff <= wd_ff[`PMC_CTRL_LFX];
			end
			irq_ff <= |(isr_ff & imr_ff);
		end
	end

	// per-mode power, clock and retention enables
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pwr_ff <= '0;
		else
		begin
			pwr_ff <= '0;
			pwr_ff.hf_src_xtal <= hfx_ff;
			pwr_ff.lf_src_xtal <= lfx_ff;
			unique case (nxt_mode)
				PM_ACTIVE, PM_IDLE:
				begin
					pwr_ff.cpu_clk <= nxt_mode == PM_ACTIVE;
					pwr_ff.flash_on <= 1'b1;
					pwr_ff.sram_on <= 1'b1;
					pwr_ff.sram_ret <= 1'b1;
					pwr_ff.reg_ret_full <= 1'b1;
					pwr_ff.radio_avail <= 1'b1;
					pwr_ff.periph_clk <= 1'b1;
					pwr_ff.hf_clk_en <= 1'b1;
					pwr_ff.mf_clk_en <= 1'b1;
					pwr_ff.lf_clk_en <= 1'b1;
					pwr_ff.sensor_ctl_on <= 1'b1;
					pwr_ff.aon_on <= 1'b1;
					pwr_ff.bod_en <= 1'b1;
					pwr_ff.por_mon <= 1'b1;
				end
				PM_STANDBY:
				begin
					pwr_ff.sram_ret <= 1'b1;
					pwr_ff.reg_ret_part <= 1'b1;
					pwr_ff.mf_clk_en <= 1'b1;
					pwr_ff.lf_clk_en <= 1'b1;
					pwr_ff.sensor_ctl_on <= 1'b1;
					pwr_ff.aon_on <= 1'b1;
					pwr_ff.supply_duty <= 1'b1;
					pwr_ff.bod_en <= bd_ff == 4'h0;
					pwr_ff.por_mon <= 1'b1;
				end
				PM_SHUTDOWN, PM_HELD: pwr_ff.flash_on <= 1'b0;
			endcase
		end
	end

	assign awready = awr_ff;
	assign wready = wr_ff;
	assign bvalid = bv_ff;
	assign bresp = br_ff;
	assign arready = arr_ff;
	assign rvalid = rv_ff;
	assign rdata = rd_ff;
	assign rresp = rr_ff;
	assign pad_out = pad_ff;
	assign io_hold = hold_ff;
	assign pwr = pwr_ff;
	assign mode = mode_ff;
	assign core_rst = rst_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_idle_wake;
		mode_ff == PM_IDLE && evt.cpu_irq && rp2_ff && !bite |=> mode_ff == PM_ACTIVE && pwr_ff.cpu_clk;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle did not wake on interrupt");
	property p_sb_stay;
		mode_ff == PM_STANDBY && !sb_wake && rp2_ff |=> mode_ff == PM_STANDBY;
	endproperty
	a_sb_stay: assert property (p_sb_stay) else $error("standby left without wake");
	property p_io_frozen;
		mode_ff == PM_STANDBY ##1 mode_ff == PM_STANDBY |-> $stable(pad_out) && io_hold;
	endproperty
	a_io_frozen: assert property (p_io_frozen) else $error("pads moved in standby");
	property p_sd_wake;
		sd_wake && rp2_ff |=> mode_ff == PM_HELD && cause_ff == RC_WAKE && core_rst;
	endproperty
	a_sd_wake: assert property (p_sd_wake) else $error("shutdown wake not reset");
	property p_wen_sticky;
		wen_ff && mode_ff != PM_HELD && mode_ff != PM_SHUTDOWN && nxt_mode != PM_HELD |=> wen_ff;
	endproperty
	a_wen_sticky: assert property (p_wen_sticky) else $error("watchdog enable dropped");
	property p_wdt_pause;
		mode_ff == PM_STANDBY ##1 mode_ff == PM_STANDBY |-> $stable(wcnt_ff);
	endproperty
	a_wdt_pause: assert property (p_wdt_pause) else $error("watchdog ran in standby");
	property p_bite;
		bite && rp2_ff |=> mode_ff == PM_HELD && cause_ff == RC_WDT ##1 hcnt_ff == 4'h7;
	endproperty
	a_bite: assert property (p_bite) else $error("watchdog bite did not reset");
	property p_hf_off;
		mode_ff == PM_STANDBY || mode_ff == PM_SHUTDOWN || mode_ff == PM_HELD |-> !pwr_ff.hf_clk_en && !pwr_ff.cpu_clk;
	endproperty
	a_hf_off: assert property (p_hf_off) else $error("fast clock on in low mode");
	property p_pin_held;
		!rp2_ff |=> mode_ff == PM_HELD && cause_ff == RC_PIN;
	endproperty
	a_pin_held: assert property (p_pin_held) else $error("reset pin ignored");
	property p_active_stay;
		mode_ff == PM_ACTIVE && !req_v && rp2_ff && !bite |=> mode_ff == PM_ACTIVE;
	endproperty
	a_active_stay: assert property (p_active_stay) else $error("active left unrequested");
	property p_sd_off;
		mode_ff == PM_SHUTDOWN |-> !pwr_ff.bod_en && !pwr_ff.por_mon && !pwr_ff.aon_on;
	endproperty
	a_sd_off: assert property (p_sd_off) else $error("monitor on in shutdown");

	c_idle: cover property (mode_ff == PM_IDLE ##1 mode_ff == PM_ACTIVE);
	c_sb: cover property (mode_ff == PM_STANDBY ##1 mode_ff == PM_ACTIVE);
	c_sd: cover property (sd_wake);
	c_bite: cover property (bite);
endmodule : pmc_top
`default_nettype wire
